// ===== core/ser24_pkg.sv
// Constants, register map and carrier types of the 24-bit serializer front end
package ser24_pkg;
	// ----------------------------------------
	// Widths and framing
	// ----------------------------------------
	localparam int DATA_W = 24;
	localparam int FRAME_W = DATA_W + 2;
	localparam logic EMB_START = 1'h1;
	localparam logic EMB_STOP = 1'h0;
	localparam logic [DATA_W-1:0] LFSR_SEED = 24'h5a5a5a;
	localparam logic [DATA_W-1:0] LFSR_TAPS = 24'he10000;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [31:0] CTRL_OFS = 32'h00000000;
	localparam logic [31:0] STAT_OFS = 32'h00000004;
	localparam logic [31:0] WORD_OFS = 32'h00000008;
	localparam int CTRL_W = 3;
	localparam int SLEEP_N_BIT = 0;
	localparam int DRIVE_EN_BIT = 1;
	localparam int EDGE_SEL_BIT = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h4;
	localparam int PLL_LOCK_BIT = 0;
	localparam int DRIVING_BIT = 1;
	localparam int LINK_READY_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLK_KHZ = 40000;
	localparam int RELOCK_MAX_MS = 50;
	localparam int RELOCK_TYP_MS = 5;
	localparam int RELOCK_MAX_CYC = RELOCK_MAX_MS * SYS_CLK_KHZ;
	localparam int RELOCK_TYP_CYC = RELOCK_TYP_MS * SYS_CLK_KHZ;
	localparam int WIN_W = 21;
	localparam int PLL_W = 20;

	// Serial pair as seen at the driver
	typedef struct packed {
		logic [FRAME_W-1:0] p;
		logic [FRAME_W-1:0] n;
		logic oe;
	} ser24_lane_s;

	// Training pattern generator step
	function automatic logic [DATA_W-1:0] ser24_lfsr(input logic [DATA_W-1:0] v);
		return {v[DATA_W-2:0], ^(v & LFSR_TAPS)};
	endfunction
endpackage

// ===== core/ser24_tx.sv
// Serializer front end: capture, sleep and drive control, link training
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Sleep low: outputs off, PLL stopped
// - Drive enable high: serial pair driven
// - Drive enable low: outputs off, PLL kept locked
// - Capture word on edge chosen by select
// - Output off drops receiver lock, retrain
// - Receiver lock window 50 ms after the pair starts being driven
// - Frame period equals input clock period
// - Outputs off until PLL has locked
// - Send pseudo-random words while receiver trains
module ser24_tx
	import ser24_pkg::*;
#(
	parameter int PLL_LOCK_CYC = 350000,
	parameter int RELOCK_CYC = RELOCK_MAX_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic parallel_input_clock,
	input wire logic [DATA_W-1:0] par_data,
	output ser24_lane_s serial_lane
);
	// ----------------------------------------
	// Register bus (sys_clk)
	// ----------------------------------------
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic aw_hold_r, aw_hold_nxt;
	logic w_hold_r, w_hold_nxt;
	logic [31:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [CTRL_W-1:0] status;
	logic [DATA_W-1:0] word_snap_r;
	logic link_ready_r;
	logic drive_s1, drive_s2;
	logic pll_s1, pll_s2;
	logic pll_lock_r, pll_lock_nxt;
	logic snap_req_s1, snap_req_s2, snap_seen_r;
	logic wstrb0_r, wstrb0_nxt;

	assign status = {link_ready_r, drive_s2, pll_s2};

	// Address decode shared by both directions
	function automatic logic ofs_hit(input logic [31:0] a, input logic [31:0] o);
		return a[31:2] == o[31:2];
	endfunction

	// Write and read channels; address and data may arrive in either order
	always_comb begin
		ctrl_nxt = ctrl_r;
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb0_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_hold_r && w_hold_r && !bvalid_r) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			if (ofs_hit(awaddr_r, CTRL_OFS)) begin
				// Strobe kept with the data; the master may move it once taken
				if (wstrb0_r) begin
					ctrl_nxt = wdata_r[CTRL_W-1:0];
				end
			end else if (ofs_hit(awaddr_r, STAT_OFS) || ofs_hit(awaddr_r, WORD_OFS)) begin
				bresp_nxt = RESP_OKAY;
			end else begin
				bresp_nxt = RESP_SLVERR;
			end
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = '0;
			if (ofs_hit(s_axi_araddr, CTRL_OFS)) begin
				rdata_nxt[CTRL_W-1:0] = ctrl_r;
			end else if (ofs_hit(s_axi_araddr, STAT_OFS)) begin
				rdata_nxt[CTRL_W-1:0] = status;
			end else if (ofs_hit(s_axi_araddr, WORD_OFS)) begin
				rdata_nxt[DATA_W-1:0] = word_snap_r;
			end else begin
				rresp_nxt = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			ctrl_r <= ctrl_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Ready flags registered so every bus output leaves a flop
	logic awready_r, wready_r, arready_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			arready_r <= 1'b0;
		end else begin
			awready_r <= !aw_hold_nxt && !bvalid_nxt && !(s_axi_awvalid && awready_r);
			wready_r <= !w_hold_nxt && !bvalid_nxt && !(s_axi_wvalid && wready_r);
			arready_r <= !rvalid_nxt && !(s_axi_arvalid && arready_r);
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_arready = arready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ----------------------------------------
	// Receiver lock window (sys_clk)
	// ----------------------------------------
	logic [WIN_W-1:0] win_cnt_r, win_cnt_nxt;
	logic link_ready_nxt;

	// Any gap in drive restarts the window; the receiver must relock
	always_comb begin
		win_cnt_nxt = win_cnt_r;
		link_ready_nxt = link_ready_r;
		if (!drive_s2) begin
			win_cnt_nxt = '0;
			link_ready_nxt = 1'b0;
		end else if (win_cnt_r == WIN_W'(RELOCK_CYC - 1)) begin
			link_ready_nxt = 1'b1;
		end else begin
			win_cnt_nxt = win_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			win_cnt_r <= '0;
			link_ready_r <= 1'b0;
		end else begin
			win_cnt_r <= win_cnt_nxt;
			link_ready_r <= link_ready_nxt;
		end
	end

	// Link state into sys_clk, two stages
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_s1 <= 1'b0;
			drive_s2 <= 1'b0;
			pll_s1 <= 1'b0;
			pll_s2 <= 1'b0;
		end else begin
			drive_s1 <= serial_lane.oe;
			drive_s2 <= drive_s1;
			pll_s1 <= pll_lock_r;
			pll_s2 <= pll_s1;
		end
	end

	// ----------------------------------------
	// Link side (parallel_input_clock)
	// ----------------------------------------
	logic [CTRL_W-1:0] ctrl_s1, ctrl_s2;
	logic rdy_s1, rdy_s2;
	logic sleep_n_s, drive_en_s, edge_s;
	logic [DATA_W-1:0] rise_r, fall_r;
	logic [PLL_W-1:0] pll_cnt_r, pll_cnt_nxt;
	logic snap_req_r, snap_req_nxt;
	logic [DATA_W-1:0] snap_hold_r, snap_hold_nxt;
	logic snap_ack_s1, snap_ack_s2;
	logic [DATA_W-1:0] lfsr_r, lfsr_nxt;
	ser24_lane_s lane_r, lane_nxt;
	logic [DATA_W-1:0] word_sel;

	assign sleep_n_s = ctrl_s2[SLEEP_N_BIT];
	assign drive_en_s = ctrl_s2[DRIVE_EN_BIT];
	assign edge_s = ctrl_s2[EDGE_SEL_BIT];

	// Control and readiness into the link domain
	always_ff @(posedge parallel_input_clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_s1 <= CTRL_RST;
			ctrl_s2 <= CTRL_RST;
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
			snap_ack_s1 <= 1'b0;
			snap_ack_s2 <= 1'b0;
		end else begin
			ctrl_s1 <= ctrl_r;
			ctrl_s2 <= ctrl_s1;
			rdy_s1 <= link_ready_r;
			rdy_s2 <= rdy_s1;
			snap_ack_s1 <= snap_seen_r;
			snap_ack_s2 <= snap_ack_s1;
		end
	end

	// Both edges sample; select picks one per period
	always_ff @(posedge parallel_input_clock or negedge rst_n) begin
		if (!rst_n) begin
			rise_r <= '0;
		end else begin
			rise_r <= par_data;
		end
	end

	always_ff @(negedge parallel_input_clock or negedge rst_n) begin
		if (!rst_n) begin
			fall_r <= '0;
		end else begin
			fall_r <= par_data;
		end
	end

	assign word_sel = edge_s ? rise_r : fall_r;

	// PLL model, training source and framed output
	always_comb begin
		pll_cnt_nxt = pll_cnt_r;
		pll_lock_nxt = pll_lock_r;
		lfsr_nxt = lfsr_r;
		lane_nxt = lane_r;
		snap_req_nxt = snap_req_r;
		snap_hold_nxt = snap_hold_r;
		if (!sleep_n_s) begin
			pll_cnt_nxt = '0;
			pll_lock_nxt = 1'b0;
		end else if (pll_cnt_r == PLL_W'(PLL_LOCK_CYC - 1)) begin
			pll_lock_nxt = 1'b1;
		end else begin
			pll_cnt_nxt = pll_cnt_r + 1'b1;
		end
		lane_nxt.oe = sleep_n_s && drive_en_s && pll_lock_r;
		if (!rdy_s2) begin
			lfsr_nxt = ser24_lfsr(lfsr_r);
			lane_nxt.p = {EMB_START, lfsr_r, EMB_STOP};
		end else begin
			lane_nxt.p = {EMB_START, word_sel, EMB_STOP};
		end
		lane_nxt.n = ~lane_nxt.p;
		// New debug word only once the last one was taken, so the hold never moves mid-copy
		if (snap_ack_s2 == snap_req_r) begin
			snap_hold_nxt = lane_r.p[FRAME_W-2:1];
			snap_req_nxt = ~snap_req_r;
		end
	end

	always_ff @(posedge parallel_input_clock or negedge rst_n) begin
		if (!rst_n) begin
			pll_cnt_r <= '0;
			pll_lock_r <= 1'b0;
			lfsr_r <= LFSR_SEED;
			lane_r <= '0;
			snap_req_r <= 1'b0;
			snap_hold_r <= '0;
		end else begin
			pll_cnt_r <= pll_cnt_nxt;
			pll_lock_r <= pll_lock_nxt;
			lfsr_r <= lfsr_nxt;
			lane_r <= lane_nxt;
			snap_req_r <= snap_req_nxt;
			snap_hold_r <= snap_hold_nxt;
		end
	end

	assign serial_lane = lane_r;

	// Debug word by toggle handshake; slow, shows only an occasional frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			snap_req_s1 <= 1'b0;
			snap_req_s2 <= 1'b0;
			snap_seen_r <= 1'b0;
			word_snap_r <= '0;
		end else begin
			snap_req_s1 <= snap_req_r;
			snap_req_s2 <= snap_req_s1;
			snap_seen_r <= snap_req_s2;
			if (snap_req_s2 != snap_seen_r) begin
				word_snap_r <= snap_hold_r; // Hold is stable until acknowledged
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_wake;
		!sleep_n_s ##1 sleep_n_s;
	endsequence

	property p_sleep_hiz;
		@(posedge parallel_input_clock) disable iff (!rst_n)
		!sleep_n_s |=> !lane_r.oe && !pll_lock_r;
	endproperty
	a_sleep_hiz: assert property (p_sleep_hiz) else $error("sleep left driver on");

	property p_drive_on;
		@(posedge parallel_input_clock) disable iff (!rst_n)
		sleep_n_s && drive_en_s && pll_lock_r |=> lane_r.oe;
	endproperty
	a_drive_on: assert property (p_drive_on) else $error("driver not enabled");

	property p_den_off;
		@(posedge parallel_input_clock) disable iff (!rst_n)
		pll_lock_r && sleep_n_s && !drive_en_s |=> pll_lock_r && !lane_r.oe;
	endproperty
	a_den_off: assert property (p_den_off) else $error("drive off lost lock");

	property p_rise_capture;
		@(posedge parallel_input_clock) disable iff (!rst_n)
		rdy_s2 && edge_s |=> lane_r.p[FRAME_W-2:1] == $past(rise_r);
	endproperty
	a_rise_capture: assert property (p_rise_capture) else $error("wrong capture edge");

	property p_wake_locks_late;
		@(posedge parallel_input_clock) disable iff (!rst_n)
		s_wake |=> !pll_lock_r && !lane_r.oe ##1 !lane_r.oe;
	endproperty
	a_wake_locks_late: assert property (p_wake_locks_late) else $error("drove before lock");

	property p_frame;
		@(posedge parallel_input_clock) disable iff (!rst_n)
		lane_r.oe |-> lane_r.p[FRAME_W-1] == EMB_START && lane_r.p[0] == EMB_STOP
			&& lane_r.n == ~lane_r.p;
	endproperty
	a_frame: assert property (p_frame) else $error("bad frame");

	property p_train;
		@(posedge parallel_input_clock) disable iff (!rst_n)
		!rdy_s2 |=> lfsr_r != $past(lfsr_r) && lane_r.p[FRAME_W-2:1] == $past(lfsr_r);
	endproperty
	a_train: assert property (p_train) else $error("training word not sent");

	property p_hiz_drops_ready;
		@(posedge sys_clk) disable iff (!rst_n)
		!drive_s2 |=> !link_ready_r && win_cnt_r == '0;
	endproperty
	a_hiz_drops_ready: assert property (p_hiz_drops_ready) else $error("ready kept");

	property p_window;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(link_ready_r) |-> $past(drive_s2) && win_cnt_r == WIN_W'(RELOCK_CYC - 1);
	endproperty
	a_window: assert property (p_window) else $error("window length wrong");

	property p_bresp_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("bvalid dropped");

endmodule // ser24_tx

`default_nettype wire

// ===== testbench/ser24_far_model.sv
// Far-side model: parallel host driving words and a receiver watching the pair
`timescale 1ns/1ps
`default_nettype none
module ser24_far_model
	import ser24_pkg::*;
#(
	parameter logic [DATA_W-1:0] RISE_W = 24'h3ca501,
	parameter logic [DATA_W-1:0] FALL_W = 24'hc35a80
) (
	input wire logic lclk,
	output logic [DATA_W-1:0] par_data,
	input wire ser24_lane_s lane,
	output logic [7:0] frame_err,
	output logic rx_locked
);
	// ----------------------------------------
	// Host side
	// ----------------------------------------
	// Each half period carries a different word, so the capture edge shows
	initial begin
		par_data = RISE_W;
		forever begin
			@(lclk);
			par_data <= lclk ? FALL_W : RISE_W;
		end
	end
	// Configuration inputs of the device are not modelled: held low by design

	// ----------------------------------------
	// Receiver side
	// ----------------------------------------
	// Lock drops whenever the pair is released; framing checked while driven
	initial begin
		frame_err = 8'h00;
		rx_locked = 1'b0;
		forever begin
			@(posedge lclk);
			if (!lane.oe) begin
				rx_locked <= 1'b0;
			end else begin
				rx_locked <= 1'b1;
				if (lane.n !== ~lane.p || lane.p[FRAME_W-1] !== EMB_START
						|| lane.p[0] !== EMB_STOP) begin
					frame_err <= frame_err + 8'h01;
				end
			end
		end
	end
endmodule // ser24_far_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the serializer front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ser24_pkg::*;
	localparam logic [DATA_W-1:0] RISE_W = 24'h3ca501;
	localparam logic [DATA_W-1:0] FALL_W = 24'hc35a80;
	logic sys_clk = 1'b0;
	logic lclk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, rx_locked;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd;
	logic [1:0] rs;
	logic [7:0] frame_err;
	logic [DATA_W-1:0] par_data;
	ser24_lane_s lane;
	int error_cnt = 0;
	int check_count = 0;

	// ----------------------------------------
	// Clocks, device and far side
	// ----------------------------------------
	// Link clock offset so the two domains never share edges
	initial forever #12.5 sys_clk = ~sys_clk;
	initial begin
		#3.1;
		forever #6 lclk = ~lclk;
	end
	ser24_tx #(.PLL_LOCK_CYC(8), .RELOCK_CYC(20)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.parallel_input_clock(lclk), .par_data(par_data), .serial_lane(lane));
	ser24_far_model #(.RISE_W(RISE_W), .FALL_W(FALL_W)) far (.lclk(lclk), .par_data(par_data),
		.lane(lane), .frame_err(frame_err), .rx_locked(rx_locked));

	// ----------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Both channels offered at once; each released as soon as it is taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		awaddr <= a; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		r = bresp;
		bready <= 1'b0;
		if (n >= 200) chk(32'h1, 32'h0);
	endtask
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 200) chk(32'h1, 32'h0);
	endtask
	// Lock time varies, so poll status against a bounded try count
	task automatic wait_stat(input logic [31:0] exp);
		int n;
		n = 0;
		do begin
			axi_rd(STAT_OFS, rd, rs);
			n++;
		end while (rd !== exp && n < 300);
	endtask
	task automatic chk_frame(input logic [DATA_W-1:0] w);
		repeat (4) @(posedge lclk);
		#1;
		chk({31'h0, lane.oe}, 32'h1);
		chk({6'h0, lane.p}, {6'h0, EMB_START, w, EMB_STOP});
		chk({6'h0, lane.n}, {6'h0, ~{EMB_START, w, EMB_STOP}});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#2000000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Reset state, unmapped access and write with strobes low
		axi_rd(CTRL_OFS, rd, rs);
		chk(rd, {29'h0, CTRL_RST});
		chk({31'h0, lane.oe}, 32'h0);
		axi_rd(32'h0000000c, rd, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		axi_wr(32'h00000010, 32'h7, 4'hf, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		axi_wr(CTRL_OFS, 32'h7, 4'h0, rs);
		axi_rd(CTRL_OFS, rd, rs);
		chk(rd, {29'h0, CTRL_RST});
		$display("test reset done");
		// Wake, drive, rising capture
		axi_wr(CTRL_OFS, 32'h7, 4'hf, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		wait_stat(32'h7);
		chk(rd, 32'h7);
		chk_frame(RISE_W);
		chk({31'h0, rx_locked}, 32'h1);
		// Debug word trails the link by a few handshakes
		repeat (20) @(posedge sys_clk);
		axi_rd(WORD_OFS, rd, rs);
		chk(rd, {8'h0, RISE_W});
		$display("test rising done");
		// Falling capture
		axi_wr(CTRL_OFS, 32'h3, 4'hf, rs);
		chk_frame(FALL_W);
		$display("test falling done");
		// Drive off: pair released, PLL stays locked, link drops
		axi_wr(CTRL_OFS, 32'h1, 4'hf, rs);
		wait_stat(32'h1);
		chk(rd, 32'h1);
		#1;
		chk({31'h0, lane.oe}, 32'h0);
		@(posedge lclk);
		#1;
		chk({31'h0, rx_locked}, 32'h0);
		// Drive back: link must train again before data
		axi_wr(CTRL_OFS, 32'h7, 4'hf, rs);
		wait_stat(32'h7);
		chk(rd, 32'h7);
		chk_frame(RISE_W);
		$display("test drive off done");
		// Sleep: pair released and PLL stopped
		axi_wr(CTRL_OFS, 32'h6, 4'hf, rs);
		wait_stat(32'h0);
		chk(rd, 32'h0);
		#1;
		chk({31'h0, lane.oe}, 32'h0);
		chk({24'h0, frame_err}, 32'h0);
		$display("test sleep done");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
